// File: supply_supervisor.sv
// supply supervisor: rail start-up, under-voltage shutdown, soft start,
// pwm/pfm select, short-circuit low-side hold until current low and the processor reset output
// assumes all comparator and enable levels are asynchronous to core_clk
//
// Overview of operation
// RQ1: start rail on supply good and enable
// RQ2: hold reset low until feedback plus 100ms
// RQ3: enable low forces reset low immediately; the code pulls it low two core_clk edges later, via the sync
// RQ4: reset is open drain, pulled up outside
// RQ5: under-voltage disables rail, with hysteresis
// RQ6: soft start raises current limit in steps
// RQ7: pwm normally, pfm at very light load
// RQ8: short holds low-side on until current low
// RQ9: supply recovery reruns power-up, then active
// RQ10: feedback dip restarts full reset delay
`timescale 1ns/1ps
`default_nettype none

module supply_supervisor #(
	parameter int unsigned POR_DELAY_CYCLES = supervisor_pkg::POR_DELAY_CYCLES,
	parameter int unsigned SS_STEP_CYCLES   = supervisor_pkg::SS_STEP_CYCLES
) (
	input  wire logic                                  core_clk,
	input  wire logic                                  sys_rst,
	input  wire logic [supervisor_pkg::RAIL_COUNT-1:0] supply_above_uv_low,
	input  wire logic [supervisor_pkg::RAIL_COUNT-1:0] supply_above_uv_high,
	input  wire logic [supervisor_pkg::RAIL_COUNT-1:0] rail_enable_in,
	input  wire logic [supervisor_pkg::RAIL_COUNT-1:0] light_load_in,
	input  wire logic [supervisor_pkg::RAIL_COUNT-1:0] output_short_in,
	input  wire logic [supervisor_pkg::RAIL_COUNT-1:0] inductor_current_low_in,
	input  wire logic                                  hv_rail_two_feedback,
	output logic      [supervisor_pkg::RAIL_COUNT-1:0] rail_run,
	output logic      [supervisor_pkg::RAIL_COUNT-1:0] supply_undervoltage_guard,
	output logic      [2*supervisor_pkg::RAIL_COUNT-1:0] ilim_step,
	output logic      [supervisor_pkg::RAIL_COUNT-1:0] pfm_mode,
	output logic      [supervisor_pkg::RAIL_COUNT-1:0] lowside_hold,
	output logic                                       proc_reset_n_out,
	output logic                                       proc_reset_n_oe
);

	localparam int unsigned N     = supervisor_pkg::RAIL_COUNT;
	localparam int unsigned SYN_W = 6 * N + 1;

	// ------------------------------------------------------------------
	// input synchronisers
	// ------------------------------------------------------------------
	logic [SYN_W-1:0] sync1_reg;
	logic [SYN_W-1:0] sync2_reg;
	logic [N-1:0]     uv_low_ok;
	logic [N-1:0]     uv_high_ok;
	logic [N-1:0]     enable_s;
	logic [N-1:0]     light_s;
	logic [N-1:0]     short_s;
	logic [N-1:0]     il_low_s;
	logic             fb_ok_s;

	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			sync1_reg <= '0;
			sync2_reg <= '0;
		end else begin
			sync1_reg <= {hv_rail_two_feedback, inductor_current_low_in, output_short_in,
				light_load_in, rail_enable_in, supply_above_uv_high, supply_above_uv_low};
			sync2_reg <= sync1_reg;
		end
	end

	assign uv_low_ok  = sync2_reg[N-1:0];
	assign uv_high_ok = sync2_reg[2*N-1:N];
	assign enable_s   = sync2_reg[3*N-1:2*N];
	assign light_s    = sync2_reg[4*N-1:3*N];
	assign short_s    = sync2_reg[5*N-1:4*N];
	assign il_low_s   = sync2_reg[6*N-1:5*N];
	assign fb_ok_s    = sync2_reg[6*N];

	// ------------------------------------------------------------------
	// per-rail supervision
	// ------------------------------------------------------------------
	genvar r;
	generate
		for (r = 0; r < N; r++) begin : g_rail
			logic                                uv_reg;
			logic                                run_reg;
			logic [1:0]                          step_reg;
			logic [supervisor_pkg::SS_CNT_W-1:0] ss_cnt_reg;
			logic                                pfm_reg;
			logic                                hold_reg;

			// --------------------------------------------------------------
			// under-voltage flag
			// --------------------------------------------------------------
			// flag sets below the falling level, clears only above the rising one,
			// so a supply sitting between the two levels cannot chatter
			always_ff @(posedge core_clk or posedge sys_rst) begin
				if (sys_rst) begin
					uv_reg <= supervisor_pkg::UV_RST[r];
				end else if (!uv_low_ok[r]) begin
					uv_reg <= 1'b1; // RQ5
				end else if (uv_high_ok[r]) begin
					uv_reg <= 1'b0; // RQ9
				end
			end

			// --------------------------------------------------------------
			// rail start
			// --------------------------------------------------------------
			always_ff @(posedge core_clk or posedge sys_rst) begin
				if (sys_rst) begin
					run_reg <= supervisor_pkg::RAIL_OFF_RST[r];
				end else begin
					run_reg <= enable_s[r] && !uv_reg && uv_low_ok[r]; // RQ1 RQ5
				end
			end

			// --------------------------------------------------------------
			// soft start current limit
			// --------------------------------------------------------------
			// each start (first, after disable or after recovery) begins at the lowest step
			always_ff @(posedge core_clk or posedge sys_rst) begin
				if (sys_rst) begin
					step_reg   <= supervisor_pkg::ILIM_STEP_FIRST;
					ss_cnt_reg <= '0;
				end else if (!run_reg) begin
					step_reg   <= supervisor_pkg::ILIM_STEP_FIRST; // RQ9
					ss_cnt_reg <= '0;
				end else if (step_reg != supervisor_pkg::ILIM_STEP_FULL) begin
					if (ss_cnt_reg == supervisor_pkg::SS_CNT_W'(SS_STEP_CYCLES - 1)) begin
						ss_cnt_reg <= '0;
						step_reg   <= step_reg + 2'h1; // RQ6
					end else begin
						ss_cnt_reg <= ss_cnt_reg + 1'b1;
					end
				end
			end

			// --------------------------------------------------------------
			// pwm / pfm select
			// --------------------------------------------------------------
			always_ff @(posedge core_clk or posedge sys_rst) begin
				if (sys_rst) begin
					pfm_reg <= 1'b0;
				end else begin
					pfm_reg <= run_reg && light_s[r]; // RQ7
				end
			end

			// --------------------------------------------------------------
			// short-circuit low-side hold
			// --------------------------------------------------------------
			// set wins over the release so a fresh short is never missed
			always_ff @(posedge core_clk or posedge sys_rst) begin
				if (sys_rst) begin
					hold_reg <= 1'b0;
				end else if (!run_reg) begin
					hold_reg <= 1'b0;
				end else if (short_s[r]) begin
					hold_reg <= 1'b1; // RQ8
				end else if (il_low_s[r]) begin
					hold_reg <= 1'b0; // RQ8
				end
			end

			assign rail_run[r]                  = run_reg;
			assign supply_undervoltage_guard[r] = uv_reg;
			assign ilim_step[2*r+1:2*r]         = step_reg;
			assign pfm_mode[r]                  = pfm_reg;
			assign lowside_hold[r]              = hold_reg;
		end
	endgenerate

	// ------------------------------------------------------------------
	// processor reset monitor
	// ------------------------------------------------------------------
	supervisor_pkg::por_state_t          por_state_reg;
	logic [supervisor_pkg::POR_CNT_W-1:0] por_cnt_reg;
	logic                                 hv2_en_s;

	assign hv2_en_s = enable_s[supervisor_pkg::HV_RAIL_TWO];

	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			por_state_reg <= supervisor_pkg::POR_HOLD;
			por_cnt_reg   <= '0;
		end else if (!hv2_en_s || !fb_ok_s) begin
			por_state_reg <= supervisor_pkg::POR_HOLD; // RQ3 RQ10
			por_cnt_reg   <= '0;
		end else begin
			unique case (por_state_reg)
				supervisor_pkg::POR_HOLD: begin
					por_state_reg <= supervisor_pkg::POR_TIMING;
					por_cnt_reg   <= '0;
				end
				// release trails the last count by one edge, plus the two sync edges:
				// a handful of clock cycles beyond the nominal delay
				supervisor_pkg::POR_TIMING: begin
					if (por_cnt_reg == supervisor_pkg::POR_CNT_W'(POR_DELAY_CYCLES - 1)) begin
						por_state_reg <= supervisor_pkg::POR_RELEASED; // RQ2
					end else begin
						por_cnt_reg <= por_cnt_reg + 1'b1;
					end
				end
				supervisor_pkg::POR_RELEASED: begin
					por_state_reg <= supervisor_pkg::POR_RELEASED;
				end
				default: begin
					por_state_reg <= supervisor_pkg::POR_HOLD;
				end
			endcase
		end
	end

	// ------------------------------------------------------------------
	// open-drain reset pin
	// ------------------------------------------------------------------
	// the pin is only ever pulled low or released; the pull-up sits on the board.
	// enable low bypasses the state register so the pull-down is not a cycle late
	assign proc_reset_n_out = 1'b0; // RQ4
	assign proc_reset_n_oe  = !hv2_en_s || (por_state_reg != supervisor_pkg::POR_RELEASED); // RQ2 RQ3

endmodule : supply_supervisor

`default_nettype wire

// File: supervisor_pkg.sv
// constants shared by the supply supervisor: rail indices, timing, states
// assumes a 25 MHz core clock; comparator levels arrive from analog front ends
`default_nettype none

package supervisor_pkg;

	// ------------------------------------------------------------------
	// rail indices
	// ------------------------------------------------------------------
	localparam int unsigned RAIL_COUNT           = 6;
	localparam int unsigned HV_RAIL_ONE          = 0;
	localparam int unsigned HV_RAIL_TWO          = 1;
	localparam int unsigned HV_RAIL_THREE        = 2;
	localparam int unsigned LV_RAIL_ONE          = 3;
	localparam int unsigned LV_RAIL_TWO          = 4;
	localparam int unsigned LINEAR_REG           = 5;

	// ------------------------------------------------------------------
	// timing
	// ------------------------------------------------------------------
	localparam int unsigned CLK_KHZ              = 25000;
	localparam int unsigned POR_DELAY_MS         = 100;
	localparam int unsigned POR_DELAY_CYCLES     = POR_DELAY_MS * CLK_KHZ;
	localparam int unsigned SS_STEP_TIME_US      = 100;
	localparam int unsigned SS_STEP_CYCLES       = SS_STEP_TIME_US * CLK_KHZ / 1000;
	localparam int unsigned POR_CNT_W            = 22;
	localparam int unsigned SS_CNT_W             = 12;

	// ------------------------------------------------------------------
	// soft start current limit steps
	// ------------------------------------------------------------------
	localparam logic [1:0]  ILIM_STEP_FIRST      = 2'h0;
	localparam logic [1:0]  ILIM_STEP_FULL       = 2'h3;

	// ------------------------------------------------------------------
	// reset values
	// ------------------------------------------------------------------
	localparam logic [RAIL_COUNT-1:0] RAIL_OFF_RST = 6'h00;
	localparam logic [RAIL_COUNT-1:0] UV_RST       = 6'h3F;

	// ------------------------------------------------------------------
	// reset monitor states
	// ------------------------------------------------------------------
	typedef enum logic [1:0] {
		POR_HOLD     = 2'b00,
		POR_TIMING   = 2'b01,
		POR_RELEASED = 2'b11
	} por_state_t;

endpackage : supervisor_pkg

`default_nettype wire

// File: supply_supervisor_assertions.sv
// checker: port relations of the supply supervisor, bound into it
// assumes 2-ff input sync, so pins reach registers 3 edges later
`timescale 1ns/1ps
`default_nettype none
module supply_supervisor_assertions #(
	parameter int unsigned POR_DELAY_CYCLES = supervisor_pkg::POR_DELAY_CYCLES
) (
	input wire logic        core_clk,
	input wire logic        sys_rst,
	input wire logic [5:0]  supply_above_uv_low,
	input wire logic [5:0]  supply_above_uv_high,
	input wire logic [5:0]  rail_enable_in,
	input wire logic [5:0]  light_load_in,
	input wire logic [5:0]  output_short_in,
	input wire logic [5:0]  inductor_current_low_in,
	input wire logic        hv_rail_two_feedback,
	input wire logic [5:0]  rail_run,
	input wire logic [5:0]  supply_undervoltage_guard,
	input wire logic [11:0] ilim_step,
	input wire logic [5:0]  pfm_mode,
	input wire logic [5:0]  lowside_hold,
	input wire logic        proc_reset_n_out,
	input wire logic        proc_reset_n_oe
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (sys_rst);
	// pin-level qualification age; saturates so it never wraps
	int unsigned qual_cnt_reg;
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) qual_cnt_reg <= 0;
		else if (!(hv_rail_two_feedback && rail_enable_in[1])) qual_cnt_reg <= 0;
		else if (qual_cnt_reg < POR_DELAY_CYCLES + 7) qual_cnt_reg <= qual_cnt_reg + 1;
	end
	// restart needs the lower level still good when the run flop samples it
	sequence s_uv_cleared;
		$fell(supply_undervoltage_guard[0]) && $past(rail_enable_in[0], 2)
			&& $past(supply_above_uv_low[0], 2);
	endsequence
	sequence s_uv_dropped;
		$fell(supply_undervoltage_guard[0]);
	endsequence
	sequence s_uv_high_seen;
		$past(supply_above_uv_high[0], 3);
	endsequence
	sequence s_step_moved;
		$changed(ilim_step[1:0]);
	endsequence
	sequence s_step_legal;
		ilim_step[1:0] == $past(ilim_step[1:0]) + 2'h1 || ilim_step[1:0] == 2'h0;
	endsequence
	sequence s_current_decayed;
		$past(inductor_current_low_in[2], 3) && !$past(output_short_in[2], 3);
	endsequence
	sequence s_reset_released;
		$fell(proc_reset_n_oe);
	endsequence
	AST_RUN_UV: assert property ((rail_run & $past(supply_undervoltage_guard)) == 6'h00)
		else $error("rail runs with uv flag");
	AST_UV_HYST: assert property (s_uv_dropped |-> s_uv_high_seen)
		else $error("uv flag cleared below upper level");
	AST_UV_RESTART: assert property (s_uv_cleared |=> rail_run[0])
		else $error("rail not restarted");
	AST_EN_LOW: assert property (!$past(rail_enable_in[1], 2) |-> proc_reset_n_oe)
		else $error("reset not pulled on disable");
	AST_OPEN_DRAIN: assert property (proc_reset_n_out == 1'b0)
		else $error("reset data not low");
	AST_DLY_MIN: assert property (s_reset_released |-> qual_cnt_reg >= POR_DELAY_CYCLES)
		else $error("reset released early");
	AST_DLY_MAX: assert property (qual_cnt_reg == POR_DELAY_CYCLES + 6 |-> !proc_reset_n_oe)
		else $error("reset released late");
	AST_SS_STEP: assert property (s_step_moved |-> s_step_legal)
		else $error("limit step skipped");
	AST_PFM: assert property (pfm_mode[2] |-> $past(light_load_in[2], 3))
		else $error("pfm without light load");
	AST_HOLD_SET: assert property ($rose(lowside_hold[2]) |-> $past(output_short_in[2], 3))
		else $error("hold without short");
	AST_HOLD_CLR: assert property (s_current_decayed |-> !lowside_hold[2])
		else $error("hold kept after current low");
endmodule : supply_supervisor_assertions
bind supply_supervisor supply_supervisor_assertions #(.POR_DELAY_CYCLES(POR_DELAY_CYCLES)) chk (
	.core_clk(core_clk), .sys_rst(sys_rst), .supply_above_uv_low(supply_above_uv_low),
	.supply_above_uv_high(supply_above_uv_high),
	.rail_enable_in(rail_enable_in), .light_load_in(light_load_in),
	.output_short_in(output_short_in), .inductor_current_low_in(inductor_current_low_in),
	.hv_rail_two_feedback(hv_rail_two_feedback), .rail_run(rail_run),
	.supply_undervoltage_guard(supply_undervoltage_guard), .ilim_step(ilim_step),
	.pfm_mode(pfm_mode), .lowside_hold(lowside_hold),
	.proc_reset_n_out(proc_reset_n_out), .proc_reset_n_oe(proc_reset_n_oe));
`default_nettype wire

// File: host_reset_sink.sv
// host side of the processor reset: pull-up resistor on the line
// assumes the supervisor only ever pulls the line low
`timescale 1ns/1ps
`default_nettype none
module host_reset_sink (
	input wire logic  proc_reset_n_out,
	input wire logic  proc_reset_n_oe,
	output wire logic host_reset_line
);
	// released line rises through the resistor, never floats
	assign host_reset_line = proc_reset_n_oe ? proc_reset_n_out : 1'b1;
endmodule : host_reset_sink
`default_nettype wire

// File: supply_supervisor_tb.sv
// testbench: start-up, uv, mode, short, reset output scenarios
// assumes short delay parameters so the run stays brief
`timescale 1ns/1ps
`default_nettype none
module supply_supervisor_tb;
	localparam int D = 20;
	logic core_clk = 1'b0;
	logic sys_rst = 1'b1;
	logic [5:0] uv_lo = 6'h3F, uv_hi = 6'h3F, en = 6'h3F, lite = 6'h00, shrt = 6'h00, ilow = 6'h00;
	logic fb = 1'b1;
	logic [5:0] run, guard, pfm, hold;
	logic [11:0] ilim;
	logic rst_out, rst_oe;
	wire logic por_line;
	int err_total = 0;
	int samples_checked = 0;
	always #20 core_clk = ~core_clk;
	supply_supervisor #(.POR_DELAY_CYCLES(D), .SS_STEP_CYCLES(4)) dut (.core_clk(core_clk),
		.sys_rst(sys_rst), .supply_above_uv_low(uv_lo), .supply_above_uv_high(uv_hi),
		.rail_enable_in(en), .light_load_in(lite), .output_short_in(shrt),
		.inductor_current_low_in(ilow), .hv_rail_two_feedback(fb), .rail_run(run),
		.supply_undervoltage_guard(guard), .ilim_step(ilim), .pfm_mode(pfm), .lowside_hold(hold),
		.proc_reset_n_out(rst_out), .proc_reset_n_oe(rst_oe));
	host_reset_sink host (.proc_reset_n_out(rst_out), .proc_reset_n_oe(rst_oe),
		.host_reset_line(por_line));
	task automatic chk(input logic ok, input string m);
		samples_checked++;
		if (ok !== 1'b1) begin
			err_total++;
			$display("wrong value at %0t: %s", $time, m);
		end
	endtask : chk
	task automatic wt(input int n);
		repeat (n) @(posedge core_clk);
		#1;
	endtask : wt
	task automatic report_and_stop;
		$display("checks %0d mismatches %0d", samples_checked, err_total);
		if (err_total == 0 && samples_checked > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask : report_and_stop
	task automatic t_start;
		wt(6);
		chk(run === 6'h3F, "rails idle");
		chk(ilim[1:0] !== 2'h3, "full limit at once");
		wt(12);
		chk(por_line === 1'b0, "reset early");
		wt(12);
		chk(por_line === 1'b1, "reset stuck");
		chk(ilim === 12'hFFF, "soft start unfinished");
		$display("startup done");
	endtask : t_start
	task automatic t_mode;
		lite[2] = 1'b1;
		wt(4);
		chk(pfm[2] === 1'b1, "no pfm");
		lite[2] = 1'b0;
		shrt[2] = 1'b1;
		ilow[2] = 1'b1;
		wt(4);
		chk(pfm[2] === 1'b0 && hold[2] === 1'b1, "pwm or hold wrong");
		shrt[2] = 1'b0;
		wt(4);
		chk(hold[2] === 1'b0, "hold stuck");
		$display("mode done");
	endtask : t_mode
	task automatic t_uv;
		uv_lo[0] = 1'b0;
		uv_hi[0] = 1'b0;
		wt(5);
		chk(guard[0] === 1'b1 && run[0] === 1'b0, "no shutdown");
		uv_lo[0] = 1'b1;
		wt(5);
		chk(guard[0] === 1'b1 && run[0] === 1'b0, "no hysteresis");
		uv_hi[0] = 1'b1;
		wt(6);
		chk(guard[0] === 1'b0 && run[0] === 1'b1, "no restart");
		chk(ilim[1:0] !== 2'h3, "soft start skipped");
		$display("uv done");
	endtask : t_uv
	task automatic t_enable;
		en[1] = 1'b0;
		wt(2);
		chk(por_line === 1'b0, "reset not pulled");
		wt(2);
		chk(run[1] === 1'b0, "rail kept on");
		en[1] = 1'b1;
		wt(D / 2);
		chk(por_line === 1'b0, "reset early");
		wt(D);
		chk(por_line === 1'b1, "reset stuck");
		$display("enable done");
	endtask : t_enable
	task automatic t_dip;
		fb = 1'b0;
		wt(3);
		chk(por_line === 1'b0, "feedback ignored");
		fb = 1'b1;
		wt(D - 5);
		fb = 1'b0;
		wt(1);
		fb = 1'b1;
		wt(D - 2);
		chk(por_line === 1'b0, "delay not restarted");
		wt(10);
		chk(por_line === 1'b1, "reset stuck");
		$display("dip done");
	endtask : t_dip
	initial begin
		#(40 * 2000);
		err_total++;
		report_and_stop();
	end
	initial begin
		wt(2);
		sys_rst = 1'b0;
		t_start();
		t_mode();
		t_uv();
		t_enable();
		t_dip();
		report_and_stop();
	end
endmodule : supply_supervisor_tb
`default_nettype wire
